//--- ccic_pkg.sv
package ccic_pkg;

    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_LEVEL = 6'h15;
    localparam logic [5:0] IDX_WDOG = 6'h16;
    localparam logic [5:0] IDX_FWD = 6'h17;
    localparam logic [5:0] IDX_HIGH = 6'h18;
    localparam logic [5:0] IDX_LOW = 6'h19;
    localparam logic [5:0] IDX_DPATH = 6'h1A;

    // ------------------------------------------------------------
    // Reset values and write keys
    // ------------------------------------------------------------
    localparam logic RST_LEVEL = 1'b1;
    localparam logic [7:0] RST_WDOG = 8'hFE;
    localparam logic [7:0] RST_FWD = 8'h1E;
    localparam logic [7:0] RST_HIGH = 8'h7F;
    localparam logic [7:0] RST_LOW = 8'h7F;
    localparam logic [7:0] KEY_SET = 8'hB5;
    localparam logic [7:0] KEY_CLR = 8'hB6;
    localparam logic SEL_3V3 = 1'b1;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int WDOG_DIS_BIT = 0;
    localparam int WDOG_TO_LSB = 1;
    localparam int FWD_PASS_BIT = 7;
    localparam int HOLD_LSB = 4;
    localparam int FILT_LSB = 0;
    localparam int AUX_BIT = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int WDOG_UNIT_NS = 2000000;
    localparam int OSC_UNIT_NS = 40;
    localparam int HOLD_UNIT_NS = 40;
    localparam int FILT_UNIT_NS = 5;
    localparam int SCL_EXTRA_UNITS = 5;
    localparam int OSC_UNIT_CYCLES =
        (OSC_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_UNIT_CYCLES =
        (HOLD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDOG_UNIT_CYCLES = WDOG_UNIT_NS / CLK_PERIOD_NS;
    localparam int STRAP_SETTLE_CYCLES = 4;

endpackage

//--- ccic_top.sv
// Notes on behaviour
// R01: Strap low selects 3.3V, high 1.8V
// R02: Digital reset returns selector to 3.3V
// R03: Level register reads selector, 1 means 3.3V
// R04: Only keys 0xB5 set, 0xB6 clear selector
// R05: Enabled watchdog aborts stalled link transactions
// R06: Timeout is field bits 7:1 times 2ms
// R07: Software never programs timeout zero
// R08: Bit 0 low enables, high disables watchdog
// R09: Pass-all low forwards only remote IDs
// R10: Pass-all high forwards all non-local IDs
// R11: SDA delayed by hold field, 40ns steps
// R12: Glitches up to filter field rejected, 5ns
// R13: Master SCL high is count plus five units
// R14: Master SCL low is count plus five units
// R15: Low count sets target setup before release
// R16: Default counts 0x7F give long enough phases
// R17: Data-path bit 3 shows aux audio enable
// R18: Watchdog restarts per transaction, stops when done
`timescale 1ns/1ps
module ccic_top #(
    parameter int WDOG_UNIT_CYCLES = ccic_pkg::WDOG_UNIT_CYCLES
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Straps and chip controls
    input wire logic strap_level_pin,
    input wire logic digital_reset_req,
    input wire logic aux_audio_ctrl,
    output logic bus_level_selector,
    // Control link transactions
    input wire logic link_txn_start,
    input wire logic link_txn_done,
    output logic link_txn_abort,
    // Target ID forwarding
    input wire logic target_id_valid,
    input wire logic [6:0] target_id,
    input wire logic [6:0] remote_deser_id,
    input wire logic [6:0] remote_target_id,
    input wire logic [6:0] local_target_id,
    output logic forward_decided,
    output logic forward_grant,
    // Local serial bus pins
    input wire logic scl_pin_in,
    input wire logic sda_pin_in,
    output logic scl_filtered,
    output logic sda_filtered,
    output logic scl_o,
    output logic scl_oe,
    // Master and target clock control
    input wire logic master_active,
    input wire logic target_stretch_start,
    output logic stretch_release
);

    if (WDOG_UNIT_CYCLES < 2) begin : gen_param_check
        $error("WDOG_UNIT_CYCLES must be at least 2");
    end

    localparam int PRE_W = $clog2(WDOG_UNIT_CYCLES);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(WDOG_UNIT_CYCLES - 1);

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic [5:0] idx;
    logic setup;
    logic wr_en;
    logic mapped;
    logic level_sel_reg;
    logic [7:0] wdog_reg;
    logic [7:0] fwd_reg;
    logic [7:0] high_reg;
    logic [7:0] low_reg;
    logic [31:0] rdata_next;

    assign idx = paddr[7:2];
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign mapped = (paddr[1:0] == 2'h0) && (idx >= ccic_pkg::IDX_LEVEL)
        && (idx <= ccic_pkg::IDX_DPATH);

    always_comb begin
        rdata_next = 32'h0;
        case (idx)
            ccic_pkg::IDX_LEVEL: rdata_next[0] = level_sel_reg; // R03
            ccic_pkg::IDX_WDOG: rdata_next[7:0] = wdog_reg;
            ccic_pkg::IDX_FWD: rdata_next[7:0] = fwd_reg;
            ccic_pkg::IDX_HIGH: rdata_next[7:0] = high_reg;
            ccic_pkg::IDX_LOW: rdata_next[7:0] = low_reg;
            ccic_pkg::IDX_DPATH: begin
                rdata_next[ccic_pkg::AUX_BIT] = aux_audio_ctrl; // R17
            end
            default: rdata_next = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            if (setup) begin
                pslverr <= !mapped;
                prdata <= (pwrite || !mapped) ? 32'h0 : rdata_next;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Config registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_reg <= ccic_pkg::RST_WDOG;
            fwd_reg <= ccic_pkg::RST_FWD;
            high_reg <= ccic_pkg::RST_HIGH; // R16
            low_reg <= ccic_pkg::RST_LOW; // R16
        end else if (wr_en) begin
            case (idx)
                ccic_pkg::IDX_WDOG: wdog_reg <= pwdata[7:0];
                ccic_pkg::IDX_FWD: fwd_reg <= pwdata[7:0];
                ccic_pkg::IDX_HIGH: high_reg <= pwdata[7:0];
                ccic_pkg::IDX_LOW: low_reg <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Strap capture and level selector
    // ------------------------------------------------------------
    logic strap_s1;
    logic strap_s2;
    logic [2:0] settle_cnt_reg;
    logic strap_done_reg;
    logic strap_capture;

    assign strap_capture = !strap_done_reg &&
        (settle_cnt_reg == 3'(ccic_pkg::STRAP_SETTLE_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1 <= 1'b0;
            strap_s2 <= 1'b0;
        end else begin
            strap_s1 <= strap_level_pin;
            strap_s2 <= strap_s1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt_reg <= 3'h0;
            strap_done_reg <= 1'b0;
        end else if (strap_capture) begin
            strap_done_reg <= 1'b1;
        end else if (!strap_done_reg) begin
            settle_cnt_reg <= settle_cnt_reg + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_sel_reg <= ccic_pkg::RST_LEVEL;
        end else if (digital_reset_req) begin
            level_sel_reg <= ccic_pkg::SEL_3V3; // R02
        end else if (strap_capture) begin
            level_sel_reg <= !strap_s2; // R01
        end else if (wr_en && idx == ccic_pkg::IDX_LEVEL) begin
            if (pwdata[7:0] == ccic_pkg::KEY_SET) begin
                level_sel_reg <= 1'b1; // R04
            end else if (pwdata[7:0] == ccic_pkg::KEY_CLR) begin
                level_sel_reg <= 1'b0; // R04
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_level_selector <= ccic_pkg::RST_LEVEL;
        end else begin
            bus_level_selector <= level_sel_reg;
        end
    end

    // ------------------------------------------------------------
    // Control link watchdog
    // ------------------------------------------------------------
    logic wdog_busy_reg;
    logic [PRE_W-1:0] wdog_pre_reg;
    logic [6:0] wdog_units_reg;
    logic wdog_en;
    logic [6:0] wdog_to;
    logic wdog_tick;
    logic wdog_expire;

    assign wdog_en = !wdog_reg[ccic_pkg::WDOG_DIS_BIT]; // R08
    assign wdog_to = wdog_reg[ccic_pkg::WDOG_TO_LSB +: 7];
    assign wdog_tick = wdog_busy_reg && (wdog_pre_reg == PRE_LAST);
    assign wdog_expire = wdog_tick &&
        (({1'b0, wdog_units_reg} + 8'h01) >= {1'b0, wdog_to}); // R06

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_busy_reg <= 1'b0;
            wdog_pre_reg <= '0;
            wdog_units_reg <= 7'h0;
            link_txn_abort <= 1'b0;
        end else begin
            link_txn_abort <= 1'b0;
            if (link_txn_start) begin
                wdog_busy_reg <= wdog_en; // R18
                wdog_pre_reg <= '0;
                wdog_units_reg <= 7'h0;
            end else if (link_txn_done || !wdog_en) begin
                wdog_busy_reg <= 1'b0; // R18
            end else if (wdog_expire) begin
                wdog_busy_reg <= 1'b0;
                link_txn_abort <= 1'b1; // R05
            end else if (wdog_tick) begin
                wdog_pre_reg <= '0;
                wdog_units_reg <= wdog_units_reg + 7'h1;
            end else if (wdog_busy_reg) begin
                wdog_pre_reg <= wdog_pre_reg + PRE_W'(1);
            end
        end
    end

    // ------------------------------------------------------------
    // Target ID forwarding
    // ------------------------------------------------------------
    logic fwd_hit;

    always_comb begin
        if (fwd_reg[ccic_pkg::FWD_PASS_BIT]) begin
            fwd_hit = target_id != local_target_id; // R10
        end else begin
            fwd_hit = (target_id == remote_deser_id) ||
                (target_id == remote_target_id); // R09
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            forward_decided <= 1'b0;
            forward_grant <= 1'b0;
        end else begin
            forward_decided <= target_id_valid;
            if (target_id_valid) begin
                forward_grant <= fwd_hit;
            end
        end
    end

    // ------------------------------------------------------------
    // Glitch filter and SDA hold delay
    // ------------------------------------------------------------
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] filt_reg;
    logic [3:0] filt_cycles;
    logic [28:0] sda_line_reg;
    logic [29:0] sda_taps;
    logic [4:0] hold_tap;

    assign filt_cycles = 4'(((8'(fwd_reg[ccic_pkg::FILT_LSB +: 4])
        * 8'(ccic_pkg::FILT_UNIT_NS)) + 8'(ccic_pkg::CLK_PERIOD_NS - 1))
        / 8'(ccic_pkg::CLK_PERIOD_NS));
    assign hold_tap = 5'(fwd_reg[ccic_pkg::HOLD_LSB +: 3])
        * 5'(ccic_pkg::HOLD_UNIT_CYCLES);
    // Tap zero is the filtered bit itself, so SDA matches SCL latency
    assign sda_taps = {sda_line_reg, filt_reg[1]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 2'h3;
            pin_s2 <= 2'h3;
        end else begin
            pin_s1 <= {sda_pin_in, scl_pin_in};
            pin_s2 <= pin_s1;
        end
    end

    for (genvar g = 0; g < 2; g++) begin : gen_filt
        logic [3:0] cnt_reg;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_reg <= 4'h0;
                filt_reg[g] <= 1'b1;
            end else if (pin_s2[g] == filt_reg[g]) begin
                cnt_reg <= 4'h0;
            end else if (cnt_reg >= filt_cycles) begin
                cnt_reg <= 4'h0;
                filt_reg[g] <= pin_s2[g]; // R12
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_line_reg <= '1;
            sda_filtered <= 1'b1;
            scl_filtered <= 1'b1;
        end else begin
            sda_line_reg <= {sda_line_reg[27:0], filt_reg[1]};
            sda_filtered <= sda_taps[hold_tap]; // R11
            scl_filtered <= filt_reg[0];
        end
    end

    // ------------------------------------------------------------
    // SCL timing for master and target
    // ------------------------------------------------------------
    logic [10:0] high_cycles;
    logic [10:0] low_cycles;
    logic [10:0] phase_cnt_reg;
    logic master_low_reg;
    logic stretch_busy_reg;
    logic [10:0] stretch_cnt_reg;

    assign high_cycles = (11'(high_reg) + 11'(ccic_pkg::SCL_EXTRA_UNITS))
        * 11'(ccic_pkg::OSC_UNIT_CYCLES); // R13
    assign low_cycles = (11'(low_reg) + 11'(ccic_pkg::SCL_EXTRA_UNITS))
        * 11'(ccic_pkg::OSC_UNIT_CYCLES); // R14

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_cnt_reg <= 11'h0;
            master_low_reg <= 1'b0;
        end else if (!master_active) begin
            phase_cnt_reg <= 11'h0;
            master_low_reg <= 1'b0;
        end else if (phase_cnt_reg ==
            (master_low_reg ? low_cycles : high_cycles) - 11'h1) begin
            phase_cnt_reg <= 11'h0;
            master_low_reg <= !master_low_reg; // R13 R14
        end else begin
            phase_cnt_reg <= phase_cnt_reg + 11'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stretch_busy_reg <= 1'b0;
            stretch_cnt_reg <= 11'h0;
            stretch_release <= 1'b0;
        end else begin
            stretch_release <= 1'b0;
            if (target_stretch_start && !stretch_busy_reg) begin
                stretch_busy_reg <= 1'b1;
                stretch_cnt_reg <= 11'h0;
            end else if (stretch_busy_reg &&
                stretch_cnt_reg == low_cycles - 11'h1) begin
                stretch_busy_reg <= 1'b0;
                stretch_release <= 1'b1; // R15
            end else if (stretch_busy_reg) begin
                stretch_cnt_reg <= stretch_cnt_reg + 11'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_oe <= 1'b0;
            scl_o <= 1'b0;
        end else begin
            scl_oe <= master_low_reg || stretch_busy_reg;
            scl_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup(logic [5:0] a, logic w);
        psel && !penable && pwrite == w && idx == a && paddr[1:0] == 2'h0;
    endsequence

    AST_STRAP_LATCH: assert property ( // R01
        strap_capture && !digital_reset_req |=>
            level_sel_reg == !$past(strap_s2))
        else $error("strap level not latched into selector");
    AST_DIGRST: assert property ( // R02
        digital_reset_req |=> level_sel_reg == ccic_pkg::SEL_3V3)
        else $error("digital reset did not select 3.3V");
    AST_READ_LEVEL: assert property ( // R03
        s_setup(ccic_pkg::IDX_LEVEL, 1'b0) |=>
            pready && prdata == {31'h0, $past(level_sel_reg)})
        else $error("level register read mismatch");
    AST_KEY_ONLY: assert property ( // R04
        wr_en && idx == ccic_pkg::IDX_LEVEL && !digital_reset_req
        && !strap_capture && pwdata[7:0] != ccic_pkg::KEY_SET
        && pwdata[7:0] != ccic_pkg::KEY_CLR |=> $stable(level_sel_reg))
        else $error("unkeyed write changed selector");
    AST_WDOG_TIME: assert property ( // R06
        link_txn_abort |-> $past(wdog_tick) &&
            ($past(wdog_units_reg) + 7'h1 >= $past(wdog_to)))
        else $error("watchdog expired at wrong time");
    AST_WDOG_OFF: assert property ( // R08
        !wdog_en && !link_txn_start |=> !link_txn_abort && !wdog_busy_reg)
        else $error("disabled watchdog still active");
    AST_WDOG_DONE: assert property ( // R18
        link_txn_done && !link_txn_start |=> !wdog_busy_reg ##1
            !link_txn_abort)
        else $error("watchdog kept running after completion");
    AST_FWD_MATCH: assert property ( // R09
        target_id_valid && !fwd_reg[ccic_pkg::FWD_PASS_BIT] |=>
            forward_decided && forward_grant ==
            ($past(target_id) == $past(remote_deser_id) ||
             $past(target_id) == $past(remote_target_id)))
        else $error("forward decision wrong with pass-all low");
    AST_FWD_ALL: assert property ( // R10
        target_id_valid && fwd_reg[ccic_pkg::FWD_PASS_BIT] |=>
            forward_grant == ($past(target_id) != $past(local_target_id)))
        else $error("forward decision wrong with pass-all high");
    AST_SDA_HOLD: assert property ( // R11
        $stable(hold_tap) |=> sda_filtered == $past(sda_taps[hold_tap]))
        else $error("SDA delay tap wrong");
    AST_SCL_LOW: assert property ( // R14
        master_active && $past(master_active) && $fell(master_low_reg) |->
            $past(phase_cnt_reg) == $past(low_cycles) - 11'h1)
        else $error("master SCL low phase wrong length");
    AST_SCL_HIGH: assert property ( // R13
        master_active && $past(master_active) && $rose(master_low_reg) |->
            $past(phase_cnt_reg) == $past(high_cycles) - 11'h1)
        else $error("master SCL high phase wrong length");
    AST_STRETCH: assert property ( // R15
        stretch_release |-> $past(stretch_cnt_reg) ==
            $past(low_cycles) - 11'h1 && $past(stretch_busy_reg))
        else $error("target setup time wrong");
    AST_AUX: assert property ( // R17
        s_setup(ccic_pkg::IDX_DPATH, 1'b0) |=>
            prdata[ccic_pkg::AUX_BIT] == $past(aux_audio_ctrl))
        else $error("aux audio status wrong");

endmodule

//--- ccic_link_model.sv
`timescale 1ns/1ps
module ccic_link_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench commands
    input wire logic go,
    input wire logic [7:0] done_after,
    // Far end of the control link
    output logic link_txn_start,
    output logic link_txn_done
);
    // ------------
    // Link answers
    // ------------
    logic go_reg;
    logic [7:0] cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_reg <= 1'b0;
            link_txn_start <= 1'b0;
        end else begin
            go_reg <= go;
            link_txn_start <= go && !go_reg;
        end
    end
    // Done after done_after cycles, zero stalls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            link_txn_done <= 1'b0;
        end else begin
            link_txn_done <= cnt_reg == 8'h01;
            if (go && !go_reg) begin
                cnt_reg <= done_after;
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule

//--- control_channel_i2c_config_tb_top.sv
`timescale 1ns/1ps
module control_channel_i2c_config_tb_top;
    // ------------
    // Bench state
    // ------------
    localparam int U = 20;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, rerr, sel, abort, dec, grant;
    logic [7:0] paddr = 8'h00, done_after = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic strap = 1'b0, dig_rst = 1'b0, aux = 1'b0, go = 1'b0;
    logic tid_valid = 1'b0, mact = 1'b0, stretch = 1'b0, rel;
    logic scl_in = 1'b1, sda_in = 1'b1, scl_f, sda_f, scl_o, scl_oe;
    logic t_start, t_done;
    logic [6:0] tid = 7'h00;
    int err_total = 0, samples_checked = 0, cyc = 0;
    always #5 pclk = ~pclk;
    ccic_top #(.WDOG_UNIT_CYCLES(U)) DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .strap_level_pin(strap),
        .digital_reset_req(dig_rst), .aux_audio_ctrl(aux),
        .bus_level_selector(sel), .link_txn_start(t_start),
        .link_txn_done(t_done), .link_txn_abort(abort),
        .target_id_valid(tid_valid), .target_id(tid),
        .remote_deser_id(7'h2C), .remote_target_id(7'h50),
        .local_target_id(7'h0C), .forward_decided(dec),
        .forward_grant(grant), .scl_pin_in(scl_in), .sda_pin_in(sda_in),
        .scl_filtered(scl_f), .sda_filtered(sda_f), .scl_o(scl_o),
        .scl_oe(scl_oe), .master_active(mact),
        .target_stretch_start(stretch), .stretch_release(rel));
    ccic_link_model u_link (.pclk(pclk), .presetn(presetn), .go(go),
        .done_after(done_after), .link_txn_start(t_start),
        .link_txn_done(t_done));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("apb wait", 1, n);
    endtask
    task automatic rdc(input logic [7:0] a, e);
        apb(1'b0, a, 8'h00);
        chk($sformatf("reg %0h", a), {24'h000000, e}, rdata);
    endtask
    // ------------
    // Scenarios
    // ------------
    task automatic t_level();
        @(negedge pclk);
        chk("selector", 1, sel);
        rdc(8'h54, 8'h01);
        rdc(8'h58, 8'hFE);
        rdc(8'h5C, 8'h1E);
        rdc(8'h60, 8'h7F);
        rdc(8'h64, 8'h7F);
        strap <= 1'b1;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(negedge pclk);
        chk("selector", 0, sel);
        apb(1'b1, 8'h54, 8'hB4);
        rdc(8'h54, 8'h00);
        apb(1'b1, 8'h54, 8'hB5);
        rdc(8'h54, 8'h01);
        apb(1'b1, 8'h54, 8'hB6);
        rdc(8'h54, 8'h00);
        dig_rst <= 1'b1;
        @(posedge pclk);
        dig_rst <= 1'b0;
        rdc(8'h54, 8'h01);
        aux <= 1'b1;
        apb(1'b1, 8'h68, 8'h00);
        rdc(8'h68, 8'h08);
        apb(1'b0, 8'h6C, 8'h00);
        chk("unmapped error", 1, rerr);
    endtask
    task automatic t_wdog(input logic [6:0] f, input logic dis,
        input logic [7:0] da, input int lo);
        int n;
        n = 0;
        apb(1'b1, 8'h58, {f, dis});
        done_after <= da;
        go <= 1'b1;
        do begin
            @(negedge pclk);
            n++;
        end while (abort !== 1'b1 && n < 80);
        @(posedge pclk);
        go <= 1'b0;
        chk("abort window", 1,
            lo > 0 ? (n >= lo && n <= lo + 4) : (n == 80));
    endtask
    task automatic fwd(input logic pass, input logic [6:0] id, input e);
        apb(1'b1, 8'h5C, {pass, 7'h00});
        tid <= id;
        tid_valid <= 1'b1;
        @(posedge pclk);
        tid_valid <= 1'b0;
        @(negedge pclk);
        chk("decided", 1, dec);
        chk("grant", e, grant);
    endtask
    task automatic span(input logic lv, output int n);
        n = 0;
        while (scl_oe === lv && n < 300) begin
            n++;
            @(negedge pclk);
        end
    endtask
    task automatic t_pins();
        int nc, ns;
        nc = 0;
        ns = 0;
        apb(1'b1, 8'h5C, 8'h0E);
        scl_in <= 1'b0;
        repeat (3) @(posedge pclk);
        scl_in <= 1'b1;
        repeat (15) begin
            @(negedge pclk);
            nc += scl_f !== 1'b1;
        end
        chk("glitch seen", 0, nc);
        apb(1'b1, 8'h5C, 8'h10);
        scl_in <= 1'b0;
        sda_in <= 1'b0;
        nc = 0;
        for (int i = 1; i < 40; i++) begin
            @(negedge pclk);
            if (scl_f === 1'b0 && nc == 0) nc = i;
            if (sda_f === 1'b0 && ns == 0) ns = i;
        end
        chk("sda lag", 4, ns - nc);
        @(posedge pclk);
        scl_in <= 1'b1;
        sda_in <= 1'b1;
    endtask
    task automatic t_scl();
        int n;
        apb(1'b1, 8'h60, 8'h01);
        apb(1'b1, 8'h64, 8'h02);
        mact <= 1'b1;
        @(negedge pclk);
        span(1'b0, n);
        span(1'b1, n);
        chk("scl low", 28, n);
        span(1'b0, n);
        chk("scl high", 24, n);
        chk("scl data", 0, scl_o);
        @(posedge pclk);
        mact <= 1'b0;
        apb(1'b1, 8'h64, 8'h03);
        repeat (40) @(posedge pclk);
        stretch <= 1'b1;
        @(posedge pclk);
        stretch <= 1'b0;
        repeat (5) @(negedge pclk);
        n = 5;
        chk("stretch drive", 1, scl_oe);
        while (rel !== 1'b1 && n < 60) begin
            @(negedge pclk);
            n++;
        end
        chk("release window", 33, n);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        t_level();
        t_wdog(7'h01, 1'b0, 8'h00, U + 1);
        t_wdog(7'h02, 1'b0, 8'h00, 2 * U + 1);
        t_wdog(7'h01, 1'b0, 8'h05, 0);
        t_wdog(7'h01, 1'b1, 8'h00, 0);
        fwd(1'b0, 7'h2C, 1'b1);
        fwd(1'b0, 7'h50, 1'b1);
        fwd(1'b0, 7'h33, 1'b0);
        fwd(1'b1, 7'h33, 1'b1);
        fwd(1'b1, 7'h0C, 1'b0);
        t_pins();
        t_scl();
        stop_test();
    end
endmodule
